// [rtl/bsf_mode_ctrl.sv]
// Regulation mode selector: sink regulation or output hysteresis
module bsf_mode_ctrl (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic dominantOn,
	input wire logic outAboveUpper,
	input wire logic outBelowLower,
	output bsf_pkg::bsf_reg_type regMode,
	output logic switchReq
);
	import bsf_pkg::*;

	bsf_reg_type state;
	bsf_reg_type next_state;
	logic next_switch;

	always_comb begin
		next_state = state;
		next_switch = 1'b0;
		if (!enable) begin
			next_state = BSF_REG_IDLE;
		end else if (dominantOn) begin
			next_state = BSF_REG_SINK;
			next_switch = 1'b1;
		end else begin
			unique case (state)
				BSF_REG_IDLE, BSF_REG_SINK: begin
					next_state = BSF_REG_CLIMB;
					next_switch = !outAboveUpper;
				end
				BSF_REG_CLIMB: begin
					next_switch = !outAboveUpper;
					if (outAboveUpper) begin
						next_state = BSF_REG_HYST;
					end
				end
				BSF_REG_HYST: begin
					// Hold switching from lower until upper threshold
					if (outBelowLower) begin
						next_switch = 1'b1;
					end else if (outAboveUpper) begin
						next_switch = 1'b0;
					end else begin
						next_switch = switchReq;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= BSF_REG_IDLE;
			switchReq <= 1'b0;
		end else begin
			state <= next_state;
			switchReq <= next_switch;
		end
	end

	// Mode is reported straight from the state register
	assign regMode = state;

	climb_to_upper_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(state == BSF_REG_CLIMB && enable && !dominantOn && outAboveUpper)
		|=> state == BSF_REG_HYST && !switchReq)
		else $error("climb did not stop at upper threshold");
	sink_reg_switch_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(enable && dominantOn) |=> state == BSF_REG_SINK && switchReq)
		else $error("dominant string not regulated");
endmodule

// [rtl/bsf_pkg.sv]
// Shared constants and types for the boost startup fault supervisor
// Overview of operation
// - Soft start begins with the switch held at minimum on-time continuously.
// - After that phase, on-time follows the rising compensation level.
// - Soft-start ramp timer runs a fixed 100 ms.
// - Regulation reached or output at 90% of limit ends soft start early.
// - Dominant string on: regulate its sink pin to the target.
// - Dominant string off: switch to upper threshold, then hysteresis band.
// - Chip enable high starts gradual turn-on of input disconnect switch.
// - Input overcurrent from a direct short turns disconnect switch off.
// - Output undervoltage at startup stops the startup sequence.
// - Secondary switch-node overcurrent shuts down with no restart.
// - Secondary switch-node overvoltage shuts down with no restart.
// - Input overcurrent at startup cuts input power via disconnect switch.
// - Open or shorted-LED string is disabled alone; others keep running.
// - Sink pin ground short at startup check holds off startup.
// - Overvoltage from ground short shuts down, rechecks shorts before restart. The code does not act on it in ST_SOFTMIN, only in ST_SOFTRAMP and ST_RUN.
// - Frequency-set pin fault blocks restart until removed.
// - Lost external sync falls back to resistor-set frequency.
package bsf_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int SOFT_START_MS = 100;
	localparam int SOFT_START_CYC = CLK_HZ / 1000 * SOFT_START_MS;
	localparam int MIN_ON_PHASE_NS = 1000;
	localparam int MIN_ON_PHASE_CYC = (MIN_ON_PHASE_NS * 40 + 999) / 1000;
	localparam int SYNC_LOSS_NS = 5000;
	localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS * 40 / 1000;
	localparam int NUM_STRINGS = 10;

	typedef enum logic [1:0] {
		BSF_ONTIME_OFF,
		BSF_ONTIME_MIN,
		BSF_ONTIME_COMP
	} bsf_ontime_type;

	typedef enum logic [1:0] {
		BSF_REG_IDLE,
		BSF_REG_SINK,
		BSF_REG_CLIMB,
		BSF_REG_HYST
	} bsf_reg_type;
endpackage

// [rtl/bsf_supervisor.sv]
// Startup sequencer and system fault supervisor for the boost LED driver
module bsf_supervisor #(
	parameter int SOFT_START_CYCLES = bsf_pkg::SOFT_START_CYC,
	parameter int NSTR = bsf_pkg::NUM_STRINGS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic chipEnable,
	input wire logic inputOvercurrent,
	input wire logic outputUndervoltage,
	input wire logic swSecOvercurrent,
	input wire logic swSecOvervoltage,
	input wire logic outputOvervoltage,
	input wire logic outAt90Pct,
	input wire logic ledRegulated,
	input wire logic dominantOn,
	input wire logic outAboveUpper,
	input wire logic outBelowLower,
	input wire logic [NSTR-1:0] sinkGndShort,
	input wire logic [NSTR-1:0] sinkOpenOrShorted,
	input wire logic fsetFault,
	input wire logic extSync,
	output logic disconnectOn,
	output bsf_pkg::bsf_ontime_type onTimeMode,
	output logic switchEnable,
	output logic softStartActive,
	output logic [NSTR-1:0] stringEnable,
	output logic useExtClock,
	output logic latchedOff,
	output logic gndCheckActive
);
	import bsf_pkg::*;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_GNDCHECK,
		ST_SOFTMIN,
		ST_SOFTRAMP,
		ST_RUN,
		ST_LATCHED
	} bsf_state_type;

	bsf_state_type state;
	bsf_state_type next_state;
	logic [26:0] ssCount;
	logic enSync;
	logic enPrev;
	logic inOcSync;
	logic uvSync;
	logic secOcSync;
	logic secOvSync;
	logic ovpSync;
	logic at90Sync;
	logic regSync;
	logic domSync;
	logic upSync;
	logic lowSync;
	logic fsetSync;
	logic syncSync;
	logic syncPrev;
	logic [7:0] syncIdle;
	logic [NSTR-1:0] gndSync;
	logic [NSTR-1:0] badSync;
	logic [NSTR-1:0] dropped;
	logic modeSwitch;
	bsf_reg_type regMode;

	localparam logic [26:0] SS_LAST = 27'(SOFT_START_CYCLES - 1);
	localparam logic [26:0] MIN_LAST = 27'(MIN_ON_PHASE_CYC - 1);
	localparam logic [7:0] SYNC_LAST = 8'(SYNC_LOSS_CYC - 1);

	// All analog comparator outputs are asynchronous to sys_clk
	logic [12:0] rawIn;
	logic [12:0] synIn;
	assign rawIn = {chipEnable, inputOvercurrent, outputUndervoltage,
		swSecOvercurrent, swSecOvervoltage, outputOvervoltage, outAt90Pct,
		ledRegulated, dominantOn, outAboveUpper, outBelowLower, fsetFault,
		extSync};
	assign {enSync, inOcSync, uvSync, secOcSync, secOvSync, ovpSync,
		at90Sync, regSync, domSync, upSync, lowSync, fsetSync,
		syncSync} = synIn;

	for (genvar i = 0; i < 13; i++) begin : g_sync
		bsf_sync3 u_sync (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.din(rawIn[i]),
			.dout(synIn[i])
		);
	end
	for (genvar j = 0; j < NSTR; j++) begin : g_str
		bsf_sync3 u_gnd (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.din(sinkGndShort[j]),
			.dout(gndSync[j])
		);
		bsf_sync3 u_bad (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.din(sinkOpenOrShorted[j]),
			.dout(badSync[j])
		);
	end

	wire switching = state inside {ST_SOFTMIN, ST_SOFTRAMP, ST_RUN};
	wire starting = state inside {ST_GNDCHECK, ST_SOFTMIN, ST_SOFTRAMP};
	wire enRise = enSync && !enPrev;
	wire ssDone = state == ST_SOFTRAMP && (ssCount >= SS_LAST
		|| regSync || at90Sync);
	wire secFault = switching && (secOcSync || secOvSync);
	wire ovpGndShort = switching && ovpSync && |(gndSync & stringEnable);
	// Any input overcurrent is treated as a direct short: no retry
	wire inOcFault = inOcSync;
	wire fatal = secFault || inOcFault;
	wire startBlock = fsetSync || |gndSync;

	always_comb begin
		next_state = state;
		if (!enSync) begin
			next_state = ST_OFF;
		end else begin
			unique case (state)
				ST_OFF: begin
					if (enRise) begin
						next_state = ST_GNDCHECK;
					end
				end
				ST_GNDCHECK: begin
					if (inOcFault) begin
						next_state = ST_LATCHED;
					end else if (!startBlock && !uvSync) begin
						next_state = ST_SOFTMIN;
					end
				end
				ST_SOFTMIN: begin
					if (fatal) begin
						next_state = ST_LATCHED;
					end else if (uvSync) begin
						next_state = ST_GNDCHECK;
					end else if (ssCount >= MIN_LAST) begin
						next_state = ST_SOFTRAMP;
					end
				end
				ST_SOFTRAMP: begin
					if (fatal) begin
						next_state = ST_LATCHED;
					end else if (ovpGndShort) begin
						next_state = ST_GNDCHECK;
					end else if (uvSync) begin
						next_state = ST_GNDCHECK;
					end else if (ssDone) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (fatal) begin
						next_state = ST_LATCHED;
					end else if (ovpGndShort || fsetSync) begin
						next_state = ST_GNDCHECK;
					end
				end
				ST_LATCHED: begin
					next_state = ST_LATCHED;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
			enPrev <= 1'b0;
		end else begin
			state <= next_state;
			enPrev <= enSync;
		end
	end

	// One counter serves the minimum on-time phase and the ramp
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ssCount <= 27'h0000000;
		end else if (next_state != state) begin
			ssCount <= 27'h0000000;
		end else if (ssCount != SS_LAST) begin
			ssCount <= ssCount + 27'h0000001;
		end
	end

	// Strings dropped for open or shorted LEDs stay off until re-enable
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dropped <= '0;
		end else if (state == ST_OFF) begin
			dropped <= '0;
		end else if (switching && !ovpGndShort) begin
			dropped <= dropped | badSync;
		end
	end

	// Sync loss counted in sys_clk cycles since the last sync edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncPrev <= 1'b0;
			syncIdle <= SYNC_LAST;
		end else begin
			syncPrev <= syncSync;
			if (syncSync != syncPrev) begin
				syncIdle <= 8'h00;
			end else if (syncIdle != SYNC_LAST) begin
				syncIdle <= syncIdle + 8'h01;
			end
		end
	end

	bsf_mode_ctrl u_mode (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enable(state == ST_RUN),
		.dominantOn(domSync),
		.outAboveUpper(upSync),
		.outBelowLower(lowSync),
		.regMode(regMode),
		.switchReq(modeSwitch)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			disconnectOn <= 1'b0;
			onTimeMode <= BSF_ONTIME_OFF;
			switchEnable <= 1'b0;
			softStartActive <= 1'b0;
			stringEnable <= '0;
			useExtClock <= 1'b0;
			latchedOff <= 1'b0;
			gndCheckActive <= 1'b0;
		end else begin
			// Disconnect switch stays on through recheck; only OFF/latch open it
			disconnectOn <= !(next_state inside {ST_OFF, ST_LATCHED});
			onTimeMode <= next_state == ST_SOFTMIN ? BSF_ONTIME_MIN :
				(next_state inside {ST_SOFTRAMP, ST_RUN}) ?
				BSF_ONTIME_COMP : BSF_ONTIME_OFF;
			switchEnable <= (next_state inside {ST_SOFTMIN, ST_SOFTRAMP})
				|| (next_state == ST_RUN && modeSwitch);
			softStartActive <= next_state inside {ST_SOFTMIN, ST_SOFTRAMP};
			stringEnable <= (next_state inside {ST_SOFTMIN, ST_SOFTRAMP,
				ST_RUN}) ? ~(dropped | badSync) : '0;
			useExtClock <= syncIdle != SYNC_LAST;
			latchedOff <= next_state == ST_LATCHED;
			gndCheckActive <= next_state == ST_GNDCHECK;
		end
	end

	sequence en_cycle_s;
		!enSync ##1 enSync;
	endsequence

	latch_hold_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_LATCHED && enSync) |=> state == ST_LATCHED)
		else $error("latched shutdown released without enable cycle");
	// Outputs land with the state, so an early enable drop cannot misfire
	fatal_shutdown_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(enSync && switching && (secOcSync || secOvSync))
		|=> state == ST_LATCHED && !switchEnable && latchedOff)
		else $error("secondary fault did not shut down");
	inrush_off_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(enSync && inOcSync && state != ST_OFF) |-> ##2 !disconnectOn)
		else $error("input overcurrent left disconnect on");
	enable_start_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		en_cycle_s ##0 state == ST_OFF |-> ##1 disconnectOn)
		else $error("disconnect switch not turned on at enable");
	gnd_hold_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_GNDCHECK && |gndSync) |=> state != ST_SOFTMIN)
		else $error("startup left ground check with short");
	frequency_set_pin_hold_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_GNDCHECK && fsetSync) |=> state != ST_SOFTMIN)
		else $error("startup left ground check with pin fault");
	min_phase_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(state == ST_SOFTMIN) |-> onTimeMode == BSF_ONTIME_MIN)
		else $error("soft start not at minimum on-time");
	ramp_limit_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		state == ST_SOFTRAMP |-> ssCount <= SS_LAST)
		else $error("soft-start ramp overran");
	early_end_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_SOFTRAMP && enSync && !fatal && !ovpGndShort && !uvSync
		&& (regSync || at90Sync)) |=> state == ST_RUN)
		else $error("soft start did not end early");
	uv_hold_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_GNDCHECK && uvSync) |=> !softStartActive)
		else $error("startup proceeded under undervoltage");
	mode_follow_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_RUN && domSync) |=> regMode == BSF_REG_SINK)
		else $error("mode control not in sink regulation");
	string_drop_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(switching && badSync != '0)
		|=> (stringEnable & $past(badSync)) == '0)
		else $error("offending string left enabled");
	sync_fallback_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(syncIdle == SYNC_LAST) |=> !useExtClock)
		else $error("no fallback to resistor frequency");
endmodule

// [rtl/bsf_sync3.sv]
// Three-flop input synchroniser with agreement filter
module bsf_sync3 (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule

// [sim/bsf_analog_model.sv]
// Behavioural boost output stage and sync source facing the supervisor
module bsf_analog_model (
	input wire logic sys_clk,
	input wire logic switchEnable,
	input wire logic disconnectOn,
	input wire logic dominantOn,
	input wire logic syncRun,
	output logic outAboveUpper,
	output logic outBelowLower,
	output logic extSync
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] level;
	logic [2:0] div;
	logic charge;
	initial begin
		level = 6'h00;
		div = 3'h0;
		extSync = 1'b0;
	end
	// Output only rises while input power is connected
	assign charge = switchEnable && disconnectOn;
	always @(posedge sys_clk) begin
		// Sink loop pins the output while the dominant string is lit
		if (dominantOn)
			level <= 6'h20;
		else if (charge && level != 6'h3F)
			level <= level + 6'h01;
		else if (!charge && level != 6'h00)
			level <= level - 6'h01;
		div <= div + 3'h1;
		// Sync line stands still when the source is unplugged
		if (syncRun && div == 3'h7)
			extSync <= ~extSync;
	end
	assign outAboveUpper = level >= 6'h30;
	assign outBelowLower = level <= 6'h10;
endmodule

// [sim/testbench.sv]
// Self-checking testbench for the boost startup fault supervisor
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import bsf_pkg::*;
	localparam int SS = 200;
	logic sys_clk, rst_n, chipEnable, outputUndervoltage;
	logic outputOvervoltage, outAt90Pct, ledRegulated, dominantOn;
	logic fsetFault, syncRun, extSync, outAboveUpper, outBelowLower;
	logic [2:0] flt;
	logic [9:0] sinkGndShort, sinkOpenOrShorted, stringEnable;
	logic disconnectOn, switchEnable, softStartActive;
	logic useExtClock, latchedOff, gndCheckActive;
	bsf_ontime_type onTimeMode;
	int num_errors, cmp_count;
	bsf_supervisor #(.SOFT_START_CYCLES(SS), .NSTR(10)) bsf_supervisor_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .chipEnable(chipEnable),
		.inputOvercurrent(flt[0]), .outputUndervoltage(outputUndervoltage),
		.swSecOvercurrent(flt[1]), .swSecOvervoltage(flt[2]),
		.outputOvervoltage(outputOvervoltage), .outAt90Pct(outAt90Pct),
		.ledRegulated(ledRegulated), .dominantOn(dominantOn),
		.outAboveUpper(outAboveUpper), .outBelowLower(outBelowLower),
		.sinkGndShort(sinkGndShort), .sinkOpenOrShorted(sinkOpenOrShorted),
		.fsetFault(fsetFault), .extSync(extSync),
		.disconnectOn(disconnectOn), .onTimeMode(onTimeMode),
		.switchEnable(switchEnable), .softStartActive(softStartActive),
		.stringEnable(stringEnable), .useExtClock(useExtClock),
		.latchedOff(latchedOff), .gndCheckActive(gndCheckActive));
	bsf_analog_model bsf_analog_model_inst (
		.sys_clk(sys_clk), .switchEnable(switchEnable),
		.disconnectOn(disconnectOn), .dominantOn(dominantOn),
		.syncRun(syncRun), .outAboveUpper(outAboveUpper),
		.outBelowLower(outBelowLower), .extSync(extSync));
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task results;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Settle one step past the edge so registered outputs have landed
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task enRise;
		@(posedge sys_clk) chipEnable <= 1'b0;
		cyc(10);
		@(posedge sys_clk) chipEnable <= 1'b1;
	endtask
	task start(input logic early);
		@(posedge sys_clk) ledRegulated <= 1'b0;
		enRise;
		cyc(60);
		@(posedge sys_clk) ledRegulated <= early;
		cyc(10);
	endtask
	task sStartup;
		enRise;
		cyc(8);
		chk("disc", disconnectOn, 1'b1);
		chk("ontime", onTimeMode, BSF_ONTIME_MIN);
		chk("strings", stringEnable, 10'h3FF);
		cyc(45);
		chk("ontime", onTimeMode, BSF_ONTIME_COMP);
		cyc(100);
		chk("soft", softStartActive, 1'b1);
		cyc(150);
		chk("soft", softStartActive, 1'b0);
	endtask
	task sEarly;
		for (int k = 0; k < 2; k++) begin
			start(1'b0);
			// First pass ends soft start on regulation, second on the 90% level
			@(posedge sys_clk) begin
				if (k == 0)
					ledRegulated <= 1'b1;
				else
					outAt90Pct <= 1'b1;
			end
			cyc(10);
			chk("soft", softStartActive, 1'b0);
			@(posedge sys_clk) outAt90Pct <= 1'b0;
		end
	endtask
	task sMode;
		start(1'b1);
		@(posedge sys_clk) dominantOn <= 1'b1;
		cyc(12);
		chk("sw", switchEnable, 1'b1);
		@(posedge sys_clk) dominantOn <= 1'b0;
		cyc(8);
		chk("climb", switchEnable, 1'b1);
		for (int i = 0; i < 100 && !outAboveUpper; i++) @(posedge sys_clk);
		cyc(10);
		chk("sw", switchEnable, 1'b0);
		for (int i = 0; i < 100 && !outBelowLower; i++) @(posedge sys_clk);
		cyc(10);
		chk("sw", switchEnable, 1'b1);
	endtask
	task sString;
		start(1'b1);
		@(posedge sys_clk) sinkOpenOrShorted <= 10'h008;
		cyc(10);
		chk("strings", stringEnable, 10'h3F7);
		chk("latch", latchedOff, 1'b0);
		@(posedge sys_clk) sinkOpenOrShorted <= 10'h000;
	endtask
	task sLatch;
		for (int k = 0; k < 3; k++) begin
			start(1'b0);
			@(posedge sys_clk) flt[k] <= 1'b1;
			cyc(10);
			chk("latch", latchedOff, 1'b1);
			chk("sw", switchEnable, 1'b0);
			if (k == 0)
				chk("disc", disconnectOn, 1'b0);
			@(posedge sys_clk) flt[k] <= 1'b0;
			cyc(20);
			chk("latch", latchedOff, 1'b1);
			start(1'b1);
			chk("latch", latchedOff, 1'b0);
			chk("disc", disconnectOn, 1'b1);
		end
	endtask
	task sUnder;
		enRise;
		cyc(20);
		@(posedge sys_clk) outputUndervoltage <= 1'b1;
		cyc(10);
		chk("soft", softStartActive, 1'b0);
		chk("ontime", onTimeMode, BSF_ONTIME_OFF);
		@(posedge sys_clk) outputUndervoltage <= 1'b0;
	endtask
	task sGnd;
		@(posedge sys_clk) ledRegulated <= 1'b0;
		@(posedge sys_clk) sinkGndShort <= 10'h004;
		enRise;
		cyc(60);
		chk("gnd", gndCheckActive, 1'b1);
		chk("ontime", onTimeMode, BSF_ONTIME_OFF);
		@(posedge sys_clk) sinkGndShort <= 10'h000;
		cyc(15);
		chk("ontime", onTimeMode, BSF_ONTIME_MIN);
	endtask
	task sGndOv;
		start(1'b1);
		@(posedge sys_clk) begin
			sinkGndShort <= 10'h020;
			outputOvervoltage <= 1'b1;
		end
		cyc(10);
		chk("sw", switchEnable, 1'b0);
		chk("gnd", gndCheckActive, 1'b1);
		@(posedge sys_clk) begin
			sinkGndShort <= 10'h000;
			outputOvervoltage <= 1'b0;
		end
		cyc(15);
		chk("gnd", gndCheckActive, 1'b0);
	endtask
	task sFset;
		start(1'b1);
		@(posedge sys_clk) fsetFault <= 1'b1;
		cyc(10);
		chk("sw", switchEnable, 1'b0);
		cyc(100);
		chk("gnd", gndCheckActive, 1'b1);
		@(posedge sys_clk) fsetFault <= 1'b0;
		cyc(15);
		chk("gnd", gndCheckActive, 1'b0);
	endtask
	task sSync;
		start(1'b1);
		@(posedge sys_clk) syncRun <= 1'b1;
		cyc(60);
		chk("ext", useExtClock, 1'b1);
		@(posedge sys_clk) syncRun <= 1'b0;
		cyc(260);
		chk("ext", useExtClock, 1'b0);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Whole sequence needs at most about 2400 cycles
	initial begin
		#400us;
		num_errors++;
		results;
	end
	initial begin
		{rst_n, chipEnable, outputUndervoltage, outputOvervoltage} = 4'h0;
		{outAt90Pct, ledRegulated, dominantOn, fsetFault, syncRun} = 5'h00;
		flt = 3'h0;
		sinkGndShort = 10'h000;
		sinkOpenOrShorted = 10'h000;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		sStartup;
		sEarly;
		sMode;
		sString;
		sLatch;
		sUnder;
		sGnd;
		sGndOv;
		sFset;
		sSync;
		results;
	end
endmodule
